// ===== shh_bkend_model.sv
// ==========
// back end: delayed done strobes, stuck-routine option, buffer writer
module shh_bkend_model (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        save_req,
  input  wire        st_start,
  input  wire        log_req,
  input  wire        log_write,
  input  wire        offl_start,
  input  wire        offl_stop,
  input  wire [2:0]  dly,
  input  wire [2:0]  mode,
  output wire        save_done,
  output wire        thr_exceeded,
  output wire        st_done,
  output wire        st_fail,
  output wire [7:0]  st_result,
  output wire        log_done,
  output reg         offl_busy,
  output reg         bk_buf_we,
  output wire [6:0]  bk_buf_addr,
  output wire [31:0] bk_buf_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] sv_r, st_r, lg_r, of_r;
  reg       tog_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sv_r, st_r, lg_r, of_r} <= 32'h0;
      {tog_r, offl_busy, bk_buf_we} <= 3'h0;
    end else begin
      sv_r <= {sv_r[6:0], save_req};
      st_r <= {st_r[6:0], st_start};
      lg_r <= {lg_r[6:0], log_req};
      of_r <= {of_r[6:0], offl_stop};
      tog_r <= ~tog_r;
      bk_buf_we <= log_req & ~log_write;
      if (offl_start) offl_busy <= 1'b1;
      else if (of_r[dly] & ~mode[2]) offl_busy <= 1'b0;
    end
  end
  // side lines mean nothing without their strobe, so they toggle then
  assign save_done    = sv_r[dly];
  assign thr_exceeded = save_done ? mode[0] : tog_r;
  assign st_done      = st_r[dly];
  assign st_fail      = st_done ? mode[1] : tog_r;
  assign st_result    = st_done ? {7'h00, mode[1]} : {8{tog_r}};
  assign log_done     = lg_r[dly];
  assign bk_buf_addr  = 7'h00;
  assign bk_buf_wdata = 32'hA5C30F1E;
endmodule

// ===== shh_defs.vh
// Functional notes
// - autosave count zero disables autosave
// - F1h enables; other nonzero aborts, unchanged
// - autosave state kept non-volatile
// - autosave: busy, apply, unbusy, interrupt
// - disable monitoring also disables autosave
// - save attributes now, ignoring autosave
// - sector number selects off-line/captive operation
// - off-line: complete first, no busy
// - new command stops routine within 2s
// - captive: busy, test, record, complete
// - captive fail: error, abort, F4h/2Ch
// - log read: count one, one sector
// - log read of 03h/07h aborts
// - log write one sector; read-only aborts
// - no monitoring before enable
// - monitoring state persists; re-enable harmless
// - enable then save attributes
// - disable then save attributes
// - while disabled abort all but enable
// - return status ok: 4Fh/C2h
// - threshold exceeded: F4h/2Ch
`ifndef SHH_DEFS_VH
`define SHH_DEFS_VH
// ============================================================
// register map (byte addresses)
`define SHH_A_TASK      8'h00
`define SHH_A_CMD       8'h04
`define SHH_A_STAT      8'h08
`define SHH_A_DATA      8'h0C
`define SHH_A_STATE     8'h10
// ============================================================
// commands and subcommands
`define SHH_OP_HEALTH   8'hB0
`define SHH_SC_AUTOSV   8'hD2
`define SHH_SC_SAVE     8'hD3
`define SHH_SC_IMMED    8'hD4
`define SHH_SC_LOGRD    8'hD5
`define SHH_SC_LOGWR    8'hD6
`define SHH_SC_ENABLE   8'hD8
`define SHH_SC_DISABLE  8'hD9
`define SHH_SC_RSTAT    8'hDA
`define SHH_AS_OFF      8'h00
`define SHH_AS_ON       8'hF1
`define SHH_IM_COLLECT  8'h00
`define SHH_IM_SHORT    8'h01
`define SHH_IM_EXT      8'h02
`define SHH_IM_SEL      8'h04
`define SHH_IM_ABORT    8'h7F
`define SHH_IM_CSHORT   8'h81
`define SHH_IM_CEXT     8'h82
`define SHH_IM_CSEL     8'h84
`define SHH_LOG_DIR     8'h00
`define SHH_LOG_SUM     8'h01
`define SHH_LOG_XERR    8'h03
`define SHH_LOG_ST      8'h06
`define SHH_LOG_XST     8'h07
`define SHH_LOG_SELST   8'h09
`define SHH_LOG_HOSTHI  3'h4
`define SHH_LOG_HOSTLO  5'h1F
`define SHH_ONE_SECT    8'h01
`define SHH_GOOD_LO     8'h4F
`define SHH_GOOD_HI     8'hC2
`define SHH_BAD_LO      8'hF4
`define SHH_BAD_HI      8'h2C
// ============================================================
// sector buffer: 512 bytes as 128 words
`define SHH_BUF_LAST    7'h7F
`define SHH_ZERO_PTR    7'h00
// ============================================================
// timing: service deadline for a host command during off-line work
`define SHH_CLK_KHZ     125000
`define SHH_SVC_MS      2000
`define SHH_SVC_CYC     (`SHH_SVC_MS * `SHH_CLK_KHZ)
`define SHH_SVC_W       28
`endif

// ===== shh_div.v
`include "shh_defs.vh"
// ============================================================
// deadline counter: expire rises once run has stood for period cycles and stays high while run holds
module shh_div #(
  parameter [`SHH_SVC_W-1:0] PERIOD = `SHH_SVC_CYC
) (
  input  wire pclk,
  input  wire presetn,
  input  wire run,
  output reg  expire
);
  reg [`SHH_SVC_W-1:0] cnt_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= {`SHH_SVC_W{1'b0}};
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (!run) begin
        cnt_r <= {`SHH_SVC_W{1'b0}};
      end else if (cnt_r == PERIOD - 1'b1) begin
        expire <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule

// ===== shh_nvbit.v
`include "shh_defs.vh"
// ============================================================
// persistent flag: reloaded from the store after reset, every change written back
module shh_nvbit (
  input  wire pclk,
  input  wire presetn,
  input  wire init,
  input  wire set,
  input  wire clr,
  output reg  q,
  output reg  wr
);
  reg loaded_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_r <= 1'b0;
      q        <= 1'b0;
      wr       <= 1'b0;
    end else begin
      loaded_r <= 1'b1;
      wr       <= 1'b0;
      if (!loaded_r) begin
        q <= init;
      end else if (set) begin
        q  <= 1'b1;
        wr <= 1'b1;
      end else if (clr) begin
        q  <= 1'b0;
        wr <= 1'b1;
      end
    end
  end
endmodule

// ===== shh_top.v
// Local design decisions: the register addresses and the APB slave port.
`include "shh_defs.vh"
// ============================================================
// health-monitoring subcommand handler behind an APB register window
module shh_top #(
  parameter [`SHH_SVC_W-1:0] SVC_TIMEOUT_CYC = `SHH_SVC_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         intrq,
  input  wire        nv_smart_init,
  input  wire        nv_autosave_init,
  output wire        nv_smart_val,
  output wire        nv_smart_wr,
  output wire        nv_autosave_val,
  output wire        nv_autosave_wr,
  output reg         monitor_en,
  output reg         autosave_active,
  output reg         save_req,
  output reg         save_prefail,
  input  wire        save_done,
  input  wire        thr_exceeded,
  output reg         offl_start,
  output reg  [7:0]  offl_kind,
  output reg         offl_stop,
  output reg         offl_resume,
  input  wire        offl_busy,
  output reg         st_start,
  output reg  [7:0]  st_kind,
  input  wire        st_done,
  input  wire        st_fail,
  input  wire [7:0]  st_result,
  output reg         log_req,
  output reg         log_write,
  output reg  [7:0]  log_addr,
  input  wire        log_done,
  input  wire        bk_buf_we,
  input  wire [6:0]  bk_buf_addr,
  input  wire [31:0] bk_buf_wdata,
  output reg  [31:0] bk_buf_rdata
);
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_STOP = 4'h1;
  localparam [3:0] S_EXEC = 4'h2;
  localparam [3:0] S_SAVE = 4'h3;
  localparam [3:0] S_ST   = 4'h4;
  localparam [3:0] S_LOGX = 4'h5;
  localparam [3:0] S_DIN  = 4'h6;
  localparam [3:0] S_DOUT = 4'h7;
  localparam [3:0] S_DONE = 4'h8;

  reg [3:0]  state_r;
  reg [7:0]  op_r;
  reg [7:0]  feat_r;
  reg [7:0]  scnt_r;
  reg [7:0]  snum_r;
  reg        bsy_r;
  reg        drq_r;
  reg        err_r;
  reg        abrt_r;
  reg [7:0]  cyl_lo_r;
  reg [7:0]  cyl_hi_r;
  reg [7:0]  st_stat_r;
  reg [6:0]  ptr_r;
  reg        intr_r;
  reg        drop_r;
  reg        offl_pend_r;
  reg        rstat_r;
  reg        save_dly_r;
  reg        smart_set;
  reg        smart_clr;
  reg        as_set;
  reg        as_clr;
  reg [31:0] buf_mem [0:127];

  wire smart_q;
  wire as_q;
  wire svc_expire;

  assign nv_smart_val    = smart_q;
  assign nv_autosave_val = as_q;

  // ============================================================
  // persistent feature state
  shh_nvbit u_nv_smart (
    .pclk    (pclk),
    .presetn (presetn),
    .init    (nv_smart_init),
    .set     (smart_set),
    .clr     (smart_clr),
    .q       (smart_q),
    .wr      (nv_smart_wr)
  );

  shh_nvbit u_nv_autosave (
    .pclk    (pclk),
    .presetn (presetn),
    .init    (nv_autosave_init),
    .set     (as_set),
    .clr     (as_clr),
    .q       (as_q),
    .wr      (nv_autosave_wr)
  );

  shh_div #(
    .PERIOD (SVC_TIMEOUT_CYC)
  ) u_svc_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (state_r == S_STOP),
    .expire  (svc_expire)
  );

  // ============================================================
  // APB decode: answer in the first access cycle
  wire setup_ph  = psel & ~penable;
  wire acc_done  = psel & penable & pready;
  wire wr_task   = acc_done & pwrite & (paddr == `SHH_A_TASK);
  wire wr_cmd    = acc_done & pwrite & (paddr == `SHH_A_CMD);
  wire rd_stat   = acc_done & ~pwrite & (paddr == `SHH_A_STAT);
  wire wr_data   = acc_done & pwrite & (paddr == `SHH_A_DATA) & (state_r == S_DIN);
  wire rd_data   = acc_done & ~pwrite & (paddr == `SHH_A_DATA) & (state_r == S_DOUT);
  wire addr_ok   = (paddr == `SHH_A_TASK) | (paddr == `SHH_A_CMD) | (paddr == `SHH_A_STAT) |
                   (paddr == `SHH_A_DATA) | (paddr == `SHH_A_STATE);
  wire [7:0] status_b = {bsy_r, 1'b1, 1'b0, 1'b1, drq_r, 2'b00, err_r};
  wire [7:0] error_b  = {5'h00, abrt_r, 2'b00};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~addr_ok;
      if (setup_ph & ~pwrite) begin
        case (paddr)
          `SHH_A_TASK:  prdata <= {8'h00, snum_r, scnt_r, feat_r};
          `SHH_A_STAT:  prdata <= {cyl_hi_r, cyl_lo_r, error_b, status_b};
          `SHH_A_DATA:  prdata <= buf_mem[ptr_r];
          `SHH_A_STATE: prdata <= {16'h0000, st_stat_r, 4'h0, offl_busy, as_q, smart_q, monitor_en};
          default:      prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ============================================================
  // sector buffer: a host data write wins over a back-end write in the same cycle
  always @(posedge pclk) begin
    if (wr_data) begin
      buf_mem[ptr_r] <= pwdata;
    end else if (bk_buf_we) begin
      buf_mem[bk_buf_addr] <= bk_buf_wdata;
    end
    bk_buf_rdata <= buf_mem[bk_buf_addr];
  end

  // ============================================================
  // subcommand decode of the latched task file
  wire is_health  = (op_r == `SHH_OP_HEALTH);
  wire log_ro     = (snum_r == `SHH_LOG_DIR) | (snum_r == `SHH_LOG_SUM) | (snum_r == `SHH_LOG_ST);
  wire log_rw     = (snum_r == `SHH_LOG_SELST) | (snum_r[7:5] == `SHH_LOG_HOSTHI);
  wire log_ext    = (snum_r == `SHH_LOG_XERR) | (snum_r == `SHH_LOG_XST);
  wire one_sect   = (scnt_r == `SHH_ONE_SECT);
  wire im_offline = (snum_r == `SHH_IM_COLLECT) | (snum_r == `SHH_IM_SHORT) |
                    (snum_r == `SHH_IM_EXT) | (snum_r == `SHH_IM_SEL);
  wire im_captive = (snum_r == `SHH_IM_CSHORT) | (snum_r == `SHH_IM_CEXT) | (snum_r == `SHH_IM_CSEL);
  // these supersede an interrupted routine, every other command lets it resume
  wire drops_offl = is_health & ((feat_r == `SHH_SC_IMMED) | (feat_r == `SHH_SC_DISABLE));

  // ============================================================
  // command sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r         <= S_IDLE;
      op_r            <= 8'h00;
      feat_r          <= 8'h00;
      scnt_r          <= 8'h00;
      snum_r          <= 8'h00;
      bsy_r           <= 1'b0;
      drq_r           <= 1'b0;
      err_r           <= 1'b0;
      abrt_r          <= 1'b0;
      cyl_lo_r        <= 8'h00;
      cyl_hi_r        <= 8'h00;
      st_stat_r       <= 8'h00;
      ptr_r           <= `SHH_ZERO_PTR;
      intr_r          <= 1'b0;
      drop_r          <= 1'b0;
      offl_pend_r     <= 1'b0;
      rstat_r         <= 1'b0;
      save_dly_r      <= 1'b0;
      intrq           <= 1'b0;
      monitor_en      <= 1'b0;
      autosave_active <= 1'b0;
      save_req        <= 1'b0;
      save_prefail    <= 1'b0;
      offl_start      <= 1'b0;
      offl_kind       <= 8'h00;
      offl_stop       <= 1'b0;
      offl_resume     <= 1'b0;
      st_start        <= 1'b0;
      st_kind         <= 8'h00;
      log_req         <= 1'b0;
      log_write       <= 1'b0;
      log_addr        <= 8'h00;
      smart_set       <= 1'b0;
      smart_clr       <= 1'b0;
      as_set          <= 1'b0;
      as_clr          <= 1'b0;
    end else begin
      // delayed save lands after the flag has moved, so it stores the new state
      save_req    <= save_dly_r;
      save_dly_r  <= 1'b0;
      offl_start  <= 1'b0;
      offl_stop   <= 1'b0;
      offl_resume <= 1'b0;
      st_start    <= 1'b0;
      log_req     <= 1'b0;
      smart_set   <= 1'b0;
      smart_clr   <= 1'b0;
      as_set      <= 1'b0;
      as_clr      <= 1'b0;
      monitor_en      <= smart_q;
      autosave_active <= smart_q & as_q;
      // a completion in the same cycle as a status read keeps the interrupt
      if (rd_stat) begin
        intrq <= 1'b0;
      end
      if (wr_task & ~bsy_r) begin
        feat_r <= pwdata[7:0];
        scnt_r <= pwdata[15:8];
        snum_r <= pwdata[23:16];
      end
      case (state_r)
        S_IDLE: begin
          if (wr_cmd & ~bsy_r) begin
            op_r        <= pwdata[7:0];
            bsy_r       <= 1'b1;
            err_r       <= 1'b0;
            abrt_r      <= 1'b0;
            drop_r      <= 1'b0;
            rstat_r     <= 1'b0;
            offl_pend_r <= 1'b0;
            intr_r      <= offl_busy;
            if (offl_busy) begin
              offl_stop <= 1'b1;
              state_r   <= S_STOP;
            end else begin
              state_r <= S_EXEC;
            end
          end
        end
        S_STOP: begin
          // the deadline bounds the wait; a late back end is overridden
          if (!offl_busy | svc_expire) begin
            state_r <= S_EXEC;
          end
        end
        S_EXEC: begin
          drop_r  <= drops_offl;
          state_r <= S_DONE;
          if (!is_health) begin
            state_r <= S_DONE;
          end else if (!smart_q & (feat_r != `SHH_SC_ENABLE)) begin
            err_r  <= 1'b1;
            abrt_r <= 1'b1;
          end else begin
            case (feat_r)
              `SHH_SC_AUTOSV: begin
                if (scnt_r == `SHH_AS_OFF) begin
                  as_clr <= 1'b1;
                end else if (scnt_r == `SHH_AS_ON) begin
                  as_set <= 1'b1;
                end else begin
                  err_r  <= 1'b1;
                  abrt_r <= 1'b1;
                end
              end
              `SHH_SC_SAVE: begin
                save_req <= 1'b1;
                state_r  <= S_SAVE;
              end
              `SHH_SC_IMMED: begin
                if (im_offline) begin
                  offl_pend_r <= 1'b1;
                  offl_kind   <= snum_r;
                end else if (snum_r == `SHH_IM_ABORT) begin
                  state_r <= S_DONE;
                end else if (im_captive) begin
                  st_start <= 1'b1;
                  st_kind  <= snum_r;
                  state_r  <= S_ST;
                end else begin
                  err_r  <= 1'b1;
                  abrt_r <= 1'b1;
                end
              end
              `SHH_SC_LOGRD: begin
                if (log_ext | ~(log_ro | log_rw) | ~one_sect) begin
                  err_r  <= 1'b1;
                  abrt_r <= 1'b1;
                end else begin
                  log_req   <= 1'b1;
                  log_write <= 1'b0;
                  log_addr  <= snum_r;
                  state_r   <= S_LOGX;
                end
              end
              `SHH_SC_LOGWR: begin
                if (~log_rw | ~one_sect) begin
                  err_r  <= 1'b1;
                  abrt_r <= 1'b1;
                end else begin
                  drq_r   <= 1'b1;
                  ptr_r   <= `SHH_ZERO_PTR;
                  state_r <= S_DIN;
                end
              end
              `SHH_SC_ENABLE: begin
                // an already-set flag is set and written back again, and the attributes are saved
                smart_set <= 1'b1;
                save_dly_r <= 1'b1;
                state_r   <= S_SAVE;
              end
              `SHH_SC_DISABLE: begin
                smart_clr <= 1'b1;
                as_clr    <= 1'b1;
                save_dly_r <= 1'b1;
                state_r   <= S_SAVE;
              end
              `SHH_SC_RSTAT: begin
                save_req     <= 1'b1;
                save_prefail <= 1'b1;
                rstat_r      <= 1'b1;
                state_r      <= S_SAVE;
              end
              default: begin
                err_r  <= 1'b1;
                abrt_r <= 1'b1;
              end
            endcase
          end
        end
        S_SAVE: begin
          if (save_done) begin
            save_prefail <= 1'b0;
            state_r      <= S_DONE;
            if (rstat_r & thr_exceeded) begin
              cyl_lo_r <= `SHH_BAD_LO;
              cyl_hi_r <= `SHH_BAD_HI;
            end else if (rstat_r) begin
              cyl_lo_r <= `SHH_GOOD_LO;
              cyl_hi_r <= `SHH_GOOD_HI;
            end
          end
        end
        S_ST: begin
          if (st_done) begin
            st_stat_r <= st_result;
            state_r   <= S_DONE;
            if (st_fail) begin
              err_r    <= 1'b1;
              abrt_r   <= 1'b1;
              cyl_lo_r <= `SHH_BAD_LO;
              cyl_hi_r <= `SHH_BAD_HI;
            end
          end
        end
        S_LOGX: begin
          if (log_done & log_write) begin
            state_r <= S_DONE;
          end else if (log_done) begin
            drq_r   <= 1'b1;
            ptr_r   <= `SHH_ZERO_PTR;
            state_r <= S_DOUT;
          end
        end
        S_DIN: begin
          if (wr_data) begin
            ptr_r <= ptr_r + 1'b1;
            if (ptr_r == `SHH_BUF_LAST) begin
              drq_r     <= 1'b0;
              log_req   <= 1'b1;
              log_write <= 1'b1;
              log_addr  <= snum_r;
              state_r   <= S_LOGX;
            end
          end
        end
        S_DOUT: begin
          if (rd_data) begin
            ptr_r <= ptr_r + 1'b1;
            if (ptr_r == `SHH_BUF_LAST) begin
              drq_r   <= 1'b0;
              state_r <= S_DONE;
            end
          end
        end
        S_DONE: begin
          bsy_r   <= 1'b0;
          intrq   <= 1'b1;
          state_r <= S_IDLE;
          // off-line work starts only after completion and never raises busy
          offl_start  <= offl_pend_r;
          offl_resume <= intr_r & ~drop_r;
        end
        default: begin
          state_r <= S_IDLE;
          bsy_r   <= 1'b0;
          drq_r   <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ===== shh_top_bench.sv
`include "shh_defs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
// ==========
// bench
module shh_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  f;
    logic [7:0]  c;
    logic [7:0]  n;
    logic [1:0]  x;
    logic [2:0]  fl;
    logic        e;
    logic [15:0] cy;
    logic [3:0]  s;
  } shh_row_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pe;
  logic        nv_smart_init = 0, nv_autosave_init = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, q, stv;
  logic [2:0]  dly = 3'h1, mode = 3'h0;
  int          checked = 0, n_mismatch = 0;
  wire [31:0]  prdata, bk_buf_rdata, bk_buf_wdata;
  wire [7:0]   offl_kind, st_kind, st_result, log_addr;
  wire [6:0]   bk_buf_addr;
  wire pready, pslverr, intrq, nv_smart_val, nv_smart_wr, nv_autosave_val, nv_autosave_wr, monitor_en;
  wire autosave_active, save_req, save_prefail, save_done, thr_exceeded, offl_start, offl_stop;
  wire offl_resume, offl_busy, st_start, st_done, st_fail, log_req, log_write, log_done, bk_buf_we;
  // f c n xfer(1 rd 2 wr) backend-mode err cyl(0 unchecked) {ignore-autosave, autosave, smart, mon}
  shh_row_t rows [24] = '{
    '{8'hD2, 8'hF1, 8'h00, 2'h0, 3'h0, 1'h0, 16'h0000, 4'h7},
    '{8'hD2, 8'h05, 8'h00, 2'h0, 3'h0, 1'h1, 16'h0000, 4'h7},
    '{8'hD2, 8'h00, 8'h00, 2'h0, 3'h0, 1'h0, 16'h0000, 4'h3},
    '{8'hD2, 8'hF1, 8'h00, 2'h0, 3'h0, 1'h0, 16'h0000, 4'h7},
    '{8'hD3, 8'h00, 8'h00, 2'h0, 3'h0, 1'h0, 16'h0000, 4'h7},
    '{8'hDA, 8'h00, 8'h00, 2'h0, 3'h0, 1'h0, 16'hC24F, 4'h7},
    '{8'hDA, 8'h00, 8'h00, 2'h0, 3'h1, 1'h0, 16'h2CF4, 4'h7},
    '{8'hD4, 8'h00, 8'h81, 2'h0, 3'h0, 1'h0, 16'h0000, 4'h7},
    '{8'hD4, 8'h00, 8'h82, 2'h0, 3'h2, 1'h1, 16'h2CF4, 4'h7},
    '{8'hD4, 8'h00, 8'h84, 2'h0, 3'h0, 1'h0, 16'h0000, 4'h7},
    '{8'hD4, 8'h00, 8'h03, 2'h0, 3'h0, 1'h1, 16'h0000, 4'h7},
    '{8'hD4, 8'h00, 8'h7F, 2'h0, 3'h0, 1'h0, 16'h0000, 4'h7},
    '{8'hD5, 8'h01, 8'h03, 2'h0, 3'h0, 1'h1, 16'h0000, 4'h7},
    '{8'hD5, 8'h01, 8'h07, 2'h0, 3'h0, 1'h1, 16'h0000, 4'h7},
    '{8'hD5, 8'h01, 8'h06, 2'h1, 3'h0, 1'h0, 16'h0000, 4'h7},
    '{8'hD5, 8'h02, 8'h01, 2'h0, 3'h0, 1'h1, 16'h0000, 4'h7},
    '{8'hD6, 8'h01, 8'h80, 2'h2, 3'h0, 1'h0, 16'h0000, 4'h7},
    '{8'hD6, 8'h01, 8'h9F, 2'h2, 3'h0, 1'h0, 16'h0000, 4'h7},
    '{8'hD6, 8'h01, 8'hA0, 2'h0, 3'h0, 1'h1, 16'h0000, 4'h7},
    '{8'hD9, 8'h00, 8'h00, 2'h0, 3'h0, 1'h0, 16'h0000, 4'h0},
    '{8'hD9, 8'h00, 8'h00, 2'h0, 3'h0, 1'h1, 16'h0000, 4'h0},
    '{8'hD3, 8'h00, 8'h00, 2'h0, 3'h0, 1'h1, 16'h0000, 4'h0},
    '{8'hD8, 8'h00, 8'h00, 2'h0, 3'h0, 1'h0, 16'h0000, 4'hB},
    '{8'hD8, 8'h00, 8'h00, 2'h0, 3'h0, 1'h0, 16'h0000, 4'hB}};
  shh_top #(.SVC_TIMEOUT_CYC(28'h32)) i_dut (.*);
  shh_bkend_model i_bk (.*);
  always #4 pclk = ~pclk;
  task automatic rst(input logic s, input logic a);
    nv_smart_init <= s;
    nv_autosave_init <= a;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    pe = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic cmd(input shh_row_t r);
    mode <= r.fl;
    apb(1'b1, `SHH_A_TASK, {8'h00, r.n, r.c, r.f});
    apb(1'b1, `SHH_A_CMD, {24'h000000, `SHH_OP_HEALTH});
    q = 32'h0;
    while (r.x != 2'h0 && q[3] !== 1'b1) apb(1'b0, `SHH_A_STAT, 32'h0);
    for (int i = 0; i < 128 && r.x != 2'h0; i++) begin
      apb(r.x[1], `SHH_A_DATA, {8'h5A, 16'h0000, i[7:0]});
      if (r.x == 2'h1 && i == 0) `CHK(q, 32'hA5C30F1E)
    end
    while (intrq !== 1'b1) @(posedge pclk);
    apb(1'b0, `SHH_A_STAT, 32'h0);
    stv = q;
    if (r.x == 2'h2) `CHK(bk_buf_rdata, 32'h5A000000)
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    conclude();
  end
  initial begin
    rst(1'b1, 1'b0);
    foreach (rows[i]) begin
      cmd(rows[i]);
      `CHK(stv[7], 1'b0)
      `CHK({stv[0], stv[10]}, {2{rows[i].e}})
      if (rows[i].cy != 16'h0000) `CHK(stv[31:16], rows[i].cy)
      apb(1'b0, `SHH_A_STATE, 32'h0);
      `CHK({autosave_active & ~rows[i].s[3], q[1:0]}, rows[i].s[2:0])
    end
    // slow back end; routine then ignores the stop request
    dly <= 3'h5;
    cmd('{8'hD4, 8'h00, 8'h01, 2'h0, 3'h0, 1'h0, 16'h0000, 4'h7});
    `CHK(stv[7:6], 2'h1)
    apb(1'b0, `SHH_A_STATE, 32'h0);
    `CHK(q[3], 1'b1)
    cmd('{8'hD3, 8'h00, 8'h00, 2'h0, 3'h4, 1'h0, 16'h0000, 4'h7});
    `CHK(stv[0], 1'b0)
    cmd('{8'hD4, 8'h00, 8'h7F, 2'h0, 3'h0, 1'h0, 16'h0000, 4'h7});
    apb(1'b0, `SHH_A_STATE, 32'h0);
    `CHK(q[3], 1'b0)
    rst(1'b1, 1'b1);
    apb(1'b0, `SHH_A_STATE, 32'h0);
    `CHK({autosave_active, q[2:0]}, 4'hF)
    rst(1'b0, 1'b1);
    apb(1'b0, `SHH_A_STATE, 32'h0);
    `CHK({autosave_active, q[1:0]}, 3'h0)
    cmd('{8'hD3, 8'h00, 8'h00, 2'h0, 3'h0, 1'h1, 16'h0000, 4'h0});
    `CHK(stv[0], 1'b1)
    apb(1'b0, 8'hFC, 32'h0);
    `CHK(pe, 1'b1)
    conclude();
  end
endmodule

// ===== shh_top_props.sv
`include "shh_defs.vh"
// ==========
// checker
module shh_top_chk #(
  parameter [`SHH_SVC_W-1:0] SVC_TIMEOUT_CYC = `SHH_SVC_CYC
) (
  input wire       pclk,
  input wire       presetn,
  input wire       intrq,
  input wire       nv_smart_val,
  input wire       nv_smart_wr,
  input wire       nv_autosave_val,
  input wire       nv_autosave_wr,
  input wire       autosave_active,
  input wire       save_req,
  input wire       offl_start,
  input wire [7:0] offl_kind,
  input wire       offl_stop,
  input wire       st_start,
  input wire [7:0] st_kind,
  input wire       st_done,
  input wire       log_req,
  input wire       log_write,
  input wire [7:0] log_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [1:0]             age_r;
  reg [`SHH_SVC_W-1:0] wait_r;
  // age filters the load of stored flags just after reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_r  <= 2'h0;
      wait_r <= 0;
    end else begin
      if (age_r != 2'h3) age_r <= age_r + 2'h1;
      if (offl_stop) wait_r <= 1;
      else if (intrq) wait_r <= 0;
      else if (wait_r != 0) wait_r <= wait_r + 1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_done; ##[1:3] intrq; endsequence
  sequence s_saved; ##[0:4] save_req; endsequence
  property p_nv_as; age_r == 2'h3 && $changed(nv_autosave_val) |-> ##[0:1] nv_autosave_wr; endproperty
  property p_nv_sm; age_r == 2'h3 && $changed(nv_smart_val) |-> ##[0:1] nv_smart_wr; endproperty
  property p_save; age_r == 2'h3 && $changed(nv_smart_val) |-> s_saved; endproperty
  property p_as_off; !nv_smart_val [*3] |-> !autosave_active; endproperty
  property p_ro_log; log_req && !log_write |-> log_addr != 8'h03 && log_addr != 8'h07; endproperty
  property p_wr_log; log_req && log_write |-> log_addr == 8'h09 || log_addr[7:5] == 3'h4; endproperty
  property p_offl; offl_start |-> intrq && offl_kind inside {8'h00, 8'h01, 8'h02, 8'h04}; endproperty
  property p_st_kind; st_start |-> st_kind inside {8'h81, 8'h82, 8'h84}; endproperty
  property p_captive; st_start |=> !intrq until st_done; endproperty
  property p_st_end; st_done |-> s_done; endproperty
  property p_svc; wait_r <= SVC_TIMEOUT_CYC + 16; endproperty
  a_nv_as: assert property (p_nv_as) else $error("autosave flag not stored");
  a_nv_sm: assert property (p_nv_sm) else $error("monitor flag not stored");
  a_save: assert property (p_save) else $error("no save after monitor change");
  a_as_off: assert property (p_as_off) else $error("autosave while disabled");
  a_ro_log: assert property (p_ro_log) else $error("read of extended log");
  a_wr_log: assert property (p_wr_log) else $error("write to read-only log");
  a_offl: assert property (p_offl) else $error("bad off-line start");
  a_st_kind: assert property (p_st_kind) else $error("bad captive kind");
  a_captive: assert property (p_captive) else $error("done before test end");
  a_st_end: assert property (p_st_end) else $error("no done after test");
  a_svc: assert property (p_svc) else $error("service too late");
endmodule
bind shh_top shh_top_chk #(.SVC_TIMEOUT_CYC(SVC_TIMEOUT_CYC)) i_chk (.*);
